//--- common/sps_pkg.sv
// Shared constants and types for the serial link power save controller
package sps_pkg;

	// ****************************************************************
	// Clock and timing
	// ****************************************************************
	localparam int CLK_PERIOD_PS = 5000;
	localparam int WAKE_PULSE_NS = 1000;
	localparam int WAKE_PULSE_CYC = (WAKE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int INIT_IDLE_MS = 1000;
	localparam int INIT_IDLE_CYC = INIT_IDLE_MS * 200000;
	localparam int TMR_W = 32;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_INACT = 4'h4;
	localparam logic [3:0] REG_ACCESS = 4'h8;
	localparam logic [3:0] REG_WREADY = 4'hc;
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam int CTRL_FIVE_SIG = 0;
	localparam int CTRL_ALL_ACKED = 1;
	localparam int CTRL_FINISH_ACK = 2;
	localparam int CTRL_PENDING = 3;
	localparam int CTRL_WAKE_REQ = 4;
	localparam int CTRL_SELF_HOLD = 5;
	localparam int CTRL_ACTIVATED = 6;
	localparam logic [15:0] INACT_NEVER = 16'hffff;
	localparam logic [15:0] INACT_RST = 16'hffff;
	localparam logic [15:0] ACCESS_RST = 16'h0001;
	localparam logic [15:0] WREADY_RST = 16'h0001;
	localparam int INACT_UNIT_CYC = 200;

	typedef enum logic [1:0] {
		SPS_AWAKE,
		SPS_SLEEP,
		SPS_WAKE_PULSE
	} sps_state_e;

endpackage

//--- common/sps_tmr_if.sv
// Interface carrying a loadable countdown timer request and status
`timescale 1ns/10ps
interface sps_tmr_if;
	import sps_pkg::*;
	logic load;
	logic [TMR_W-1:0] value;
	logic expired;
	modport ctl (output load, output value, input expired);
	modport tmr (input load, input value, output expired);
endinterface

//--- core/sps_timer.sv
// Loadable countdown timer in core clock cycles
`timescale 1ns/10ps
module sps_timer
	import sps_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	sps_tmr_if.tmr t
);
	logic [TMR_W-1:0] cnt_q;
	logic [TMR_W-1:0] cnt_d;

	always_comb
	begin
		cnt_d = cnt_q;
		if (t.load)
		begin
			cnt_d = t.value;
		end
		else if (cnt_q != '0)
		begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	// Loaded at reset, so no timer reads as expired as reset ends
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			cnt_q <= t.value;
		else
			cnt_q <= cnt_d;
	end

	assign t.expired = (cnt_q == '0) && !t.load;
endmodule

//--- core/sps_power_ctrl.sv
// Slave side power save controller for the serial link
`timescale 1ns/10ps
// Behaviour
// - Sleep only with nothing pending and some sleep condition met.
// - All frames acked plus inactivity period without select is a sleep condition.
// - Acknowledgement of link finish event frame is a sleep condition.
// - No activity beyond initial idle timeout after power-up is a sleep condition.
// - Initial idle timeout defaults to one second.
// - Returned inactivity period governs sleep; all ones means never sleep; the code blocks only the inactivity condition on it.
// - Inactivity period runs from the last select de-assertion.
// - If wake ready delay not above access delay, may decline sleep.
// - Asleep: no data out drive, no select or attention assertion.
// - Wake pulse on select or attention line lasts one microsecond.
// - Pulse end releasing select leaves slave configured, deselected, ready.
module sps_power_ctrl
	import sps_pkg::*;
#(
	parameter int INIT_IDLE_CYCLES = INIT_IDLE_CYC
)
(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic sel_b_pin_i,
	input wire logic sclk_pin_i,
	input wire logic data_out_i,
	input wire logic data_out_en_b_i,
	output logic miso_o,
	output logic miso_oe_b_o,
	output logic sel_b_o,
	output logic sel_oe_b_o,
	output logic attn_b_o,
	output logic attn_oe_b_o,
	output logic asleep_o
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [1:0] sel_sync_q;
	logic [1:0] clk_sync_q;
	logic sel_prev_q;
	logic clk_prev_q;
	logic sel_b_s;
	logic sel_rise;
	logic sel_fall;
	logic clk_edge;

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			sel_sync_q <= 2'h3;
			clk_sync_q <= 2'h0;
			sel_prev_q <= 1'b1;
			clk_prev_q <= 1'b0;
		end
		else
		begin
			sel_sync_q <= {sel_sync_q[0], sel_b_pin_i};
			clk_sync_q <= {clk_sync_q[0], sclk_pin_i};
			sel_prev_q <= sel_sync_q[1];
			clk_prev_q <= clk_sync_q[1];
		end
	end

	assign sel_b_s = sel_sync_q[1];
	assign sel_rise = sel_b_s && !sel_prev_q;
	assign sel_fall = !sel_b_s && sel_prev_q;
	assign clk_edge = clk_sync_q[1] != clk_prev_q;

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [6:0] ctrl_q;
	logic [6:0] ctrl_d;
	logic [15:0] inact_q;
	logic [15:0] inact_d;
	logic [15:0] access_q;
	logic [15:0] access_d;
	logic [15:0] wready_q;
	logic [15:0] wready_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic finish_ack_pulse;
	logic wake_done;
	sps_state_e state_q;
	sps_state_e state_d;

	always_comb
	begin
		ctrl_d = ctrl_q;
		inact_d = inact_q;
		access_d = access_q;
		wready_d = wready_q;
		rdata_d = 32'h0;
		finish_ack_pulse = 1'b0;
		if (wake_done)
			ctrl_d[CTRL_WAKE_REQ] = 1'b0;
		if (reg_wr_i)
		begin
			case (reg_addr_i)
				REG_CTRL:
				begin
					// Finish ack is a strobe, not stored
					ctrl_d = reg_wdata_i[6:0];
					ctrl_d[CTRL_FINISH_ACK] = 1'b0;
					finish_ack_pulse = reg_wdata_i[CTRL_FINISH_ACK];
					// Set by software wins over a completion in the same cycle
					if (wake_done && !reg_wdata_i[CTRL_WAKE_REQ])
						ctrl_d[CTRL_WAKE_REQ] = 1'b0;
				end
				REG_INACT: inact_d = reg_wdata_i[15:0];
				REG_ACCESS: access_d = reg_wdata_i[15:0];
				REG_WREADY: wready_d = reg_wdata_i[15:0];
				default: ;
			endcase
		end
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				REG_STATUS: rdata_d = {24'h0, state_q == SPS_SLEEP, ctrl_q[6:3], 1'b0,
					ctrl_q[1:0]};
				REG_INACT: rdata_d = {16'h0, inact_q};
				REG_ACCESS: rdata_d = {16'h0, access_q};
				REG_WREADY: rdata_d = {16'h0, wready_q};
				default: rdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			ctrl_q <= 7'h0;
			inact_q <= INACT_RST;
			access_q <= ACCESS_RST;
			wready_q <= WREADY_RST;
			rdata_q <= 32'h0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			inact_q <= inact_d;
			access_q <= access_d;
			wready_q <= wready_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;

	// ****************************************************************
	// Timers
	// ****************************************************************
	sps_tmr_if inact_t ();
	sps_tmr_if idle_t ();
	sps_tmr_if pulse_t ();
	logic link_active;

	assign link_active = !sel_b_s || clk_edge;
	assign inact_t.load = sel_rise || !sel_b_s;
	assign inact_t.value = TMR_W'(inact_q) * TMR_W'(INACT_UNIT_CYC);
	assign idle_t.load = link_active;
	assign idle_t.value = TMR_W'(INIT_IDLE_CYCLES);
	assign pulse_t.load = state_q != SPS_WAKE_PULSE;
	assign pulse_t.value = TMR_W'(WAKE_PULSE_CYC - 1);

	sps_timer u_inact (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .t(inact_t));
	sps_timer u_idle (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .t(idle_t));
	sps_timer u_pulse (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .t(pulse_t));

	// ****************************************************************
	// Sleep decision
	// ****************************************************************
	logic cond_inact;
	logic cond_idle;
	logic finish_seen_q;
	logic finish_seen_d;
	logic idle_armed_q;
	logic idle_armed_d;
	logic decline;
	logic go_sleep;

	always_comb
	begin
		finish_seen_d = finish_seen_q || finish_ack_pulse;
		idle_armed_d = idle_armed_q && !ctrl_q[CTRL_ACTIVATED];
		if (state_q == SPS_SLEEP)
			finish_seen_d = 1'b0;
		if (finish_ack_pulse)
			finish_seen_d = 1'b1;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			finish_seen_q <= 1'b0;
			idle_armed_q <= 1'b1;
		end
		else
		begin
			finish_seen_q <= finish_seen_d;
			idle_armed_q <= idle_armed_d;
		end
	end

	// Never sleep on an all ones period; the inactivity path only
	assign cond_inact = ctrl_q[CTRL_ALL_ACKED] && inact_t.expired
		&& inact_q != INACT_NEVER;
	assign cond_idle = idle_armed_q && idle_t.expired;
	// Short wake ready delay lets software hold the slave awake
	assign decline = (wready_q <= access_q) && ctrl_q[CTRL_SELF_HOLD];
	assign go_sleep = !ctrl_q[CTRL_PENDING] && !ctrl_q[CTRL_WAKE_REQ] && !decline
		&& (cond_inact || finish_seen_q || cond_idle);

	// ****************************************************************
	// Power state
	// ****************************************************************
	always_comb
	begin
		state_d = state_q;
		wake_done = 1'b0;
		case (state_q)
			SPS_AWAKE:
				if (go_sleep)
					state_d = SPS_SLEEP;
			SPS_SLEEP:
				if (!sel_b_s)
					state_d = SPS_AWAKE;
				else if (ctrl_q[CTRL_WAKE_REQ] || (decline && ctrl_q[CTRL_PENDING]))
					state_d = SPS_WAKE_PULSE;
			SPS_WAKE_PULSE:
				if (pulse_t.expired)
				begin
					state_d = SPS_AWAKE;
					wake_done = 1'b1;
				end
			default: state_d = SPS_AWAKE;
		endcase
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			state_q <= SPS_AWAKE;
		else
			state_q <= state_d;
	end

	// ****************************************************************
	// Pin drive
	// ****************************************************************
	logic pulsing;
	logic asleep;

	assign pulsing = state_q == SPS_WAKE_PULSE;
	assign asleep = state_q == SPS_SLEEP;
	assign miso_o = data_out_i;
	assign miso_oe_b_o = asleep || data_out_en_b_i;
	assign sel_b_o = 1'b0;
	assign sel_oe_b_o = !(pulsing && !ctrl_q[CTRL_FIVE_SIG]);
	assign attn_b_o = !(pulsing && ctrl_q[CTRL_FIVE_SIG]);
	assign attn_oe_b_o = !ctrl_q[CTRL_FIVE_SIG];
	assign asleep_o = asleep;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	int unsigned pulse_len_q;
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i || !pulsing)
			pulse_len_q <= 0;
		else
			pulse_len_q <= pulse_len_q + 1;
	end

	sleep_needs_cause_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		$rose(asleep) |-> $past(!ctrl_q[CTRL_PENDING] && (cond_inact || finish_seen_q
		|| cond_idle))) else $error("sleep entered without cause");
	pending_stays_awake_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		state_q == SPS_AWAKE && ctrl_q[CTRL_WAKE_REQ] |=> !asleep)
		else $error("slept with own request pending");
	never_value_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		state_q == SPS_AWAKE && inact_q == INACT_NEVER && !finish_seen_q && !cond_idle
		|=> !asleep) else $error("all ones period used");
	select_restarts_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		!sel_b_s |=> !inact_t.expired) else $error("inactivity timer not restarted");
	quiet_asleep_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		asleep |-> miso_oe_b_o && sel_oe_b_o && attn_b_o)
		else $error("pin driven while asleep");
	pulse_width_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		$fell(pulsing) |-> $past(pulse_len_q) == WAKE_PULSE_CYC - 1)
		else $error("wake pulse width wrong");
	pulse_end_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		$fell(pulsing) |-> state_q == SPS_AWAKE && sel_oe_b_o)
		else $error("pulse did not end awake and released");
	finish_sleep_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		finish_ack_pulse && state_q == SPS_AWAKE && !reg_wdata_i[CTRL_PENDING]
		&& !reg_wdata_i[CTRL_WAKE_REQ] && !(reg_wdata_i[CTRL_SELF_HOLD] && wready_q <= access_q)
		##1 !finish_ack_pulse && sel_b_s |=> asleep)
		else $error("finish ack did not sleep");

	sleep_cov_c: cover property (@(posedge core_clk_i) $rose(asleep));
	wake_cov_c: cover property (@(posedge core_clk_i) $fell(pulsing));
	sel_wake_cov_c: cover property (@(posedge core_clk_i) asleep ##1 !asleep && !pulsing);

endmodule

//--- tb/sps_master_model.sv
// Behavioural bus master facing the power save controller
`timescale 1ns/10ps
module sps_master_model
#(
	parameter int ACCESS_NS = 5
)
(
	input wire logic go_i,
	input wire logic req_b_i,
	output logic sel_b_o,
	output logic sclk_o,
	output int frames_o
);
	// ****************************************************************
	// Frames
	// ****************************************************************
	logic busy;
	initial
	begin
		sel_b_o = 1'b1;
		sclk_o = 1'b0;
		frames_o = 0;
		busy = 1'b0;
	end
	// Clock stands low outside frames, mode 0 idle
	task automatic frame();
		busy = 1'b1;
		sel_b_o = 1'b0;
		#35;
		repeat (8)
		begin
			sclk_o = 1'b1;
			#32;
			sclk_o = 1'b0;
			#32;
		end
		sel_b_o = 1'b1;
		frames_o++;
		#64;
		busy = 1'b0;
	endtask
	always @(posedge go_i)
		if (!busy)
			frame();
	// Busy set first, so our own select edge is not taken as a request
	always @(negedge req_b_i)
		if (!busy)
		begin
			busy = 1'b1;
			#ACCESS_NS;
			wait (req_b_i);
			frame();
		end
endmodule

//--- tb/sps_power_ctrl_test.sv
// Self-checking bench for the serial link power save controller
`timescale 1ns/10ps
module sps_power_ctrl_test;
	import sps_pkg::*;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic clk, rst_b, wr, rd, dout, dout_en_b, go, five;
	logic [3:0] addr;
	logic [31:0] wdata, rdata;
	logic miso, miso_oe_b, sel_b, sel_oe_b, attn_b, attn_oe_b, asleep, msel_b, sclk;
	int frames, error_cnt, num_checks, n, w;
	// Both lines are open drain with pull-ups
	wire sel_w = msel_b & (sel_oe_b | sel_b);
	wire attn_w = attn_oe_b | attn_b;
	wire req_b = five ? attn_w : sel_w;
	sps_power_ctrl #(.INIT_IDLE_CYCLES(50)) i_dut (
		.core_clk_i(clk),
		.rst_b_i(rst_b),
		.reg_addr_i(addr),
		.reg_wdata_i(wdata),
		.reg_wr_i(wr),
		.reg_rd_i(rd),
		.reg_rdata_o(rdata),
		.sel_b_pin_i(sel_w),
		.sclk_pin_i(sclk),
		.data_out_i(dout),
		.data_out_en_b_i(dout_en_b),
		.miso_o(miso),
		.miso_oe_b_o(miso_oe_b),
		.sel_b_o(sel_b),
		.sel_oe_b_o(sel_oe_b),
		.attn_b_o(attn_b),
		.attn_oe_b_o(attn_oe_b),
		.asleep_o(asleep)
	);
	sps_master_model #(.ACCESS_NS(5)) i_master (
		.go_i(go),
		.req_b_i(req_b),
		.sel_b_o(msel_b),
		.sclk_o(sclk),
		.frames_o(frames)
	);
	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// Bounded wait step; running out ends the run
	task automatic step(input int lim);
		cyc(1);
		n++;
		if (n > lim)
		begin
			error_cnt++;
			summarize();
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	task automatic reset_dut();
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		reset_dut();
		cyc(1);
		chk({31'h0, asleep}, 32'h0);
		chk({27'h0, miso, sel_b, miso_oe_b, sel_oe_b, attn_oe_b}, 32'h13);
		rd_reg(REG_INACT, 32'hffff);
		rd_reg(REG_ACCESS, 32'h1);
		rd_reg(REG_WREADY, 32'h1);
		rd_reg(REG_STATUS, 32'h0);
		rd_reg(4'h2, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_idle_wake(input logic f);
		five = 1'b0;
		reset_dut();
		n = 0;
		while (asleep !== 1'b1) step(80);
		chk({31'h0, n > 40}, 32'h1);
		chk({29'h0, miso_oe_b, sel_oe_b, attn_b}, 32'h7);
		rd_reg(REG_STATUS, 32'h80);
		five = f;
		wr_reg(REG_CTRL, f ? 32'h51 : 32'h50);
		n = 0;
		while ((f ? attn_b : sel_oe_b) !== 1'b0) step(10);
		w = 0;
		while ((f ? attn_b : sel_oe_b) === 1'b0)
		begin
			cyc(1);
			w++;
			if (w > 300)
				step(0);
		end
		chk(32'(w), 32'(WAKE_PULSE_CYC));
		w = frames;
		n = 0;
		while (frames == w) step(500);
		chk({31'h0, asleep}, 32'h0);
		chk({31'h0, attn_oe_b}, {31'h0, !f});
		rd_reg(REG_STATUS, f ? 32'h41 : 32'h40);
		$display("test idle_wake done");
	endtask
	task automatic t_inact(input logic [15:0] per, input logic [31:0] ctrl, input logic exp);
		reset_dut();
		wr_reg(REG_INACT, {16'h0, per});
		rd_reg(REG_INACT, {16'h0, per});
		wr_reg(REG_CTRL, ctrl);
		@(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		w = frames;
		n = 0;
		while (frames == w) step(400);
		cyc(150);
		chk({31'h0, asleep}, 32'h0);
		if (exp)
		begin
			n = 0;
			while (asleep !== 1'b1) step(120);
		end
		else
			cyc(400);
		chk({31'h0, asleep}, {31'h0, exp});
		if (exp)
		begin
			// Master select alone wakes the slave, no pulse
			@(posedge clk);
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			n = 0;
			while (asleep !== 1'b0) step(10);
			chk({31'h0, n <= 4}, 32'h1);
			w = frames;
			n = 0;
			while (frames == w) step(400);
		end
		$display("test inact done");
	endtask
	task automatic t_finish();
		reset_dut();
		wr_reg(REG_CTRL, 32'h40);
		cyc(100);
		chk({31'h0, asleep}, 32'h0);
		wr_reg(REG_CTRL, 32'h44);
		n = 0;
		while (asleep !== 1'b1) step(20);
		chk({31'h0, asleep}, 32'h1);
		wr_reg(REG_CTRL, 32'h68);
		n = 0;
		while (sel_oe_b !== 1'b0) step(5);
		chk({31'h0, asleep}, 32'h0);
		$display("test finish done");
	endtask
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial
	begin
		rst_b = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		dout = 1'b1;
		dout_en_b = 1'b0;
		go = 1'b0;
		five = 1'b0;
		error_cnt = 0;
		num_checks = 0;
		t_reset();
		t_idle_wake(1'b0);
		t_idle_wake(1'b1);
		t_inact(16'h0001, 32'h42, 1'b1);
		t_inact(16'h0001, 32'h4a, 1'b0);
		t_inact(16'h0001, 32'h52, 1'b0);
		t_inact(16'hffff, 32'h42, 1'b0);
		t_finish();
		summarize();
	end
endmodule
